// file: hdl/stepper_phase_sequencer.sv
/*
  Phase distribution logic of a two-phase unipolar stepper driver: step
  clock, excitation mode, direction, enable and clear come from a host as
  asynchronous levels and are sampled on mclk (100 MHz). Drives the four
  phase gate outputs as registered levels; the power stage is elsewhere.
*/
`timescale 1ns/10ps
// Function
// - each rising step clock edge while enable is high advances excitation by one step.
// - mode low gives two-phase, mode high gives one-two-phase excitation.
// - mode is sampled on the step edge and used from then on.
// - direction low steps forward, high steps in reverse.
// - while clear is low, sequencer is reset and all phases are off.
// - while enable is low all phase outputs are forced off.
// - enable returning high resumes from the held excitation position.
// - after clear release sequencing starts with the first phase gate on.
module stepper_phase_sequencer
  import stepper_pkg::*;
#(
  parameter int MIN_PULSE_CYC = stepper_pkg::STEP_MIN_PULSE_CYC,
  parameter int MIN_CLEAR_CYC = stepper_pkg::CLEAR_MIN_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire stepper_pkg::host_inputs_t host_in,
  output stepper_pkg::phase_drive_t phase_drive,
  output stepper_pkg::step_index_t excitation_index,
  output stepper_pkg::excitation_mode_t active_mode,
  output stepper_pkg::run_state_t run_state,
  output logic short_step_pulse,
  output logic short_clear_pulse
);
  import stepper_pkg::*;

  localparam logic [PULSE_CNT_W-1:0] CNT_MAX = '1;
  localparam logic [PULSE_CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [PULSE_CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LIMIT = MIN_PULSE_CYC[PULSE_CNT_W-1:0];
  localparam logic [PULSE_CNT_W-1:0] CLEAR_LIMIT = MIN_CLEAR_CYC[PULSE_CNT_W-1:0];

  localparam seq_state_t STATE_RESET = '{
    run: ST_CLEARED,
    index: INDEX_RESET,
    mode: EXC_TWO_PHASE,
    step_prev: 1'b0,
    clear_prev: 1'b0,
    high_cnt: CNT_ZERO,
    clear_cnt: CNT_ZERO,
    short_step: 1'b0,
    short_clear: 1'b0,
    drive: PHASES_OFF
  };

  generate
    if (MIN_PULSE_CYC < 1 || MIN_PULSE_CYC >= (1 << PULSE_CNT_W)) begin : g_bad_pulse
      $error("MIN_PULSE_CYC out of counter range");
    end
    if (MIN_CLEAR_CYC < 1 || MIN_CLEAR_CYC >= (1 << PULSE_CNT_W)) begin : g_bad_clear
      $error("MIN_CLEAR_CYC out of counter range");
    end
    if ($bits(step_index_t) != 3) begin : g_bad_index
      $error("step index must address exactly eight states");
    end
  endgenerate

  // ==========================================================
  // reset release
  // assertion acts at once; release is retimed so that every flop
  // leaves reset on the same edge
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ==========================================================
  // pin synchronisers
  // each pin is filtered alone, so a mode or direction change close to a
  // step edge may land a cycle apart from it; hosts keep the setup time
  host_inputs_t pins;

  input_sync #(
    .WIDTH($bits(host_inputs_t)),
    .INIT(HOST_INPUTS_RESET)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(host_in),
    .clean(pins)
  );

  // ==========================================================
  // next excitation position
  function automatic step_index_t advance(input step_index_t idx,
                                          input excitation_mode_t mode,
                                          input logic reverse);
    step_index_t stride;
    // two-phase lands on odd states; from an even (single-phase) state
    // it first moves one place, so the sequence joins the 4-state ring
    if (mode == EXC_HALF_STEP || !idx[0]) begin
      stride = STEP_ONE;
    end else begin
      stride = STEP_TWO;
    end
    if (reverse) begin
      return step_index_t'(idx - stride);
    end
    return step_index_t'(idx + stride);
  endfunction

  // ==========================================================
  // sequencer
  seq_state_t s;
  seq_state_t next_s;
  logic step_rise;
  logic step_fall;
  logic clear_rise;
  logic clear_fall;
  logic drive_on;

  always_comb begin
    next_s = s;
    step_rise = pins.step_clock && !s.step_prev;
    step_fall = !pins.step_clock && s.step_prev;
    clear_rise = pins.sequencer_clear_low && !s.clear_prev;
    clear_fall = !pins.sequencer_clear_low && s.clear_prev;
    drive_on = pins.sequencer_clear_low && pins.enable;
    next_s.step_prev = pins.step_clock;
    next_s.clear_prev = pins.sequencer_clear_low;

    // flags drop as a clear starts; a set in that same cycle still wins
    if (clear_fall) begin
      next_s.short_clear = 1'b0;
      next_s.short_step = 1'b0;
    end

    // high-time check of the step clock; host must keep its width
    if (step_fall) begin
      next_s.high_cnt = CNT_ZERO;
      if (s.high_cnt < PULSE_LIMIT) begin
        next_s.short_step = 1'b1;
      end
    end else if (pins.step_clock && s.high_cnt != CNT_MAX) begin
      next_s.high_cnt = s.high_cnt + CNT_ONE;
    end

    // clear width check; flag stands until the next clear starts
    if (clear_rise) begin
      next_s.clear_cnt = CNT_ZERO;
      if (s.clear_cnt < CLEAR_LIMIT) begin
        next_s.short_clear = 1'b1;
      end
    end else if (!pins.sequencer_clear_low && s.clear_cnt != CNT_MAX) begin
      next_s.clear_cnt = s.clear_cnt + CNT_ONE;
    end

    // run state follows the same pins that gate the drive, so they agree
    unique case (s.run)
      ST_CLEARED: begin
        if (pins.sequencer_clear_low) begin
          next_s.run = pins.enable ? ST_RUNNING : ST_HELD;
        end
      end
      ST_RUNNING: begin
        if (!pins.sequencer_clear_low) begin
          next_s.run = ST_CLEARED;
        end else if (!pins.enable) begin
          next_s.run = ST_HELD;
        end
      end
      ST_HELD: begin
        if (!pins.sequencer_clear_low) begin
          next_s.run = ST_CLEARED;
        end else if (pins.enable) begin
          next_s.run = ST_RUNNING;
        end
      end
      default: next_s.run = ST_CLEARED;
    endcase

    if (!pins.sequencer_clear_low) begin
      next_s.index = INDEX_RESET;
      next_s.mode = EXC_TWO_PHASE;
    end else if (step_rise && pins.enable) begin
      // edges while disabled are ignored so the position is kept
      next_s.mode = excitation_mode_t'(pins.excitation_mode);
      next_s.index = advance(s.index, excitation_mode_t'(pins.excitation_mode),
                             pins.direction_select);
    end

    // outputs follow the new position in the same edge as the index
    next_s.drive = drive_on ? phase_decode(next_s.index) : PHASES_OFF;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  // no glitch reaches the gates: every output is a flop
  assign phase_drive = s.drive;
  assign excitation_index = s.index;
  assign active_mode = s.mode;
  assign run_state = s.run;
  assign short_step_pulse = s.short_step;
  assign short_clear_pulse = s.short_clear;

endmodule // stepper_phase_sequencer

// file: hdl/stepper_pkg.sv
/*
  Shared types, timing constants and phase decoding for the stepper phase
  sequencer. Assumes a 100 MHz system clock and level inputs from a host.
*/
package stepper_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_MAX_HZ = 50000;
  localparam int STEP_MIN_PULSE_NS = 10000;
  localparam int STEP_MIN_PULSE_CYC = (STEP_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_MIN_NS = 10000;
  localparam int CLEAR_MIN_CYC = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 11;

  // ==========================================================
  // types
  typedef logic [2:0] step_index_t;
  localparam step_index_t INDEX_RESET = 3'h0;
  localparam step_index_t STEP_ONE = 3'h1;
  localparam step_index_t STEP_TWO = 3'h2;

  typedef enum logic {EXC_TWO_PHASE, EXC_HALF_STEP} excitation_mode_t;
  typedef enum logic [1:0] {ST_CLEARED, ST_RUNNING, ST_HELD} run_state_t;

  typedef struct packed {
    logic phase_a;
    logic phase_one_inverse;
    logic phase_b;
    logic phase_two_inverse;
  } phase_drive_t;
  localparam phase_drive_t PHASES_OFF = 4'h0;

  typedef struct packed {
    logic step_clock;
    logic excitation_mode;
    logic direction_select;
    logic enable;
    logic sequencer_clear_low;
  } host_inputs_t;
  localparam host_inputs_t HOST_INPUTS_RESET = 5'h00;

  typedef struct packed {
    run_state_t run;
    step_index_t index;
    excitation_mode_t mode;
    logic step_prev;
    logic clear_prev;
    logic [PULSE_CNT_W-1:0] high_cnt;
    logic [PULSE_CNT_W-1:0] clear_cnt;
    logic short_step;
    logic short_clear;
    phase_drive_t drive;
  } seq_state_t;

  // ==========================================================
  // half-step table: even index one phase, odd index two phases
  function automatic phase_drive_t phase_decode(input step_index_t idx);
    phase_drive_t d;
    d = PHASES_OFF;
    unique case (idx)
      3'h0: d.phase_a = 1'b1;
      3'h1: begin
        d.phase_a = 1'b1;
        d.phase_b = 1'b1;
      end
      3'h2: d.phase_b = 1'b1;
      3'h3: begin
        d.phase_b = 1'b1;
        d.phase_one_inverse = 1'b1;
      end
      3'h4: d.phase_one_inverse = 1'b1;
      3'h5: begin
        d.phase_one_inverse = 1'b1;
        d.phase_two_inverse = 1'b1;
      end
      3'h6: d.phase_two_inverse = 1'b1;
      3'h7: begin
        d.phase_two_inverse = 1'b1;
        d.phase_a = 1'b1;
      end
    endcase
    return d;
  endfunction

endpackage

// file: hdl/input_sync.sv
/*
  Three-stage synchroniser with agreement filter for asynchronous pins.
  Assumes mclk and an already synchronised active-low reset.
*/
`timescale 1ns/10ps
module input_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } sync_state_t;

  localparam sync_state_t SYNC_RESET = {INIT, INIT, INIT, INIT};

  sync_state_t s;
  sync_state_t next_s;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("input_sync needs at least one bit");
    end
  endgenerate

  // ==========================================================
  // stage shift; a change counts only when stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.clean = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.clean);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= SYNC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign clean = s.clean;

endmodule // input_sync

// file: tb/seq_props_properties.sv
/*
  Port checker for the stepper phase sequencer.
  Assumes one mclk domain; bound to the top module below.
*/
`timescale 1ns/10ps
module seq_props
  import stepper_pkg::*;
#(parameter int MIN_PULSE_CYC = 4, parameter int MIN_CLEAR_CYC = 4) (
  input wire logic mclk,
  input wire logic nrst,
  input wire stepper_pkg::host_inputs_t host_in,
  input wire stepper_pkg::phase_drive_t phase_drive,
  input wire stepper_pkg::step_index_t excitation_index,
  input wire stepper_pkg::excitation_mode_t active_mode,
  input wire stepper_pkg::run_state_t run_state,
  input wire logic short_step_pulse,
  input wire logic short_clear_pulse
);
  // index 0 in the top nibble
  localparam logic [31:0] TBL = 32'h8A264519;
  wire st = host_in.step_clock;
  wire md = host_in.excitation_mode;
  wire dr = host_in.direction_select;
  wire en = host_in.enable;
  wire cl = host_in.sequencer_clear_low;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // output relations
  a_off_cleared: assert property (
    run_state == ST_CLEARED |-> phase_drive == PHASES_OFF) else $error("drive on in clear");
  a_off_held: assert property (
    run_state == ST_HELD |-> phase_drive == PHASES_OFF) else $error("drive on in hold");
  a_drive_table: assert property (
    run_state == ST_RUNNING |-> phase_drive == TBL[31-4*excitation_index -: 4])
    else $error("drive off table");
  a_clear_zero: assert property (
    (!cl) [*6] |-> excitation_index == INDEX_RESET && run_state == ST_CLEARED)
    else $error("clear not applied");
  // with clear high, index may only move after a step rise
  a_idle_stable: assert property (
    (!st && cl) [*8] |=> $stable(excitation_index)) else $error("index moved idle");
  a_mode_capture: assert property (
    $rose(st) && en && cl |-> ##6 active_mode == $past(md, 6)) else $error("mode not taken");
  a_two_phase_step: assert property (
    $rose(st) && en && cl && !md && excitation_index[0]
    |-> ##6 excitation_index == $past(excitation_index, 6) + ($past(dr, 6) ? 3'h6 : 3'h2))
    else $error("two-phase step wrong");
  a_half_step: assert property (
    $rose(st) && en && cl && md
    |-> ##6 excitation_index == $past(excitation_index, 6) + ($past(dr, 6) ? 3'h7 : 3'h1))
    else $error("half step wrong");
endmodule // seq_props

bind stepper_phase_sequencer seq_props #(
  .MIN_PULSE_CYC(MIN_PULSE_CYC),
  .MIN_CLEAR_CYC(MIN_CLEAR_CYC)
) u_props (
  .mclk(mclk),
  .nrst(nrst),
  .host_in(host_in),
  .phase_drive(phase_drive),
  .excitation_index(excitation_index),
  .active_mode(active_mode),
  .run_state(run_state),
  .short_step_pulse(short_step_pulse),
  .short_clear_pulse(short_clear_pulse)
);

// file: tb/host_model.sv
/*
  Host controller model driving the five level pins.
  Assumes mclk; pins change only at its falling edge.
*/
`timescale 1ns/10ps
module host_model
  import stepper_pkg::*;
(
  input wire logic mclk,
  output stepper_pkg::host_inputs_t host_in
);
  // clear asserted from time zero covers the power-up hold
  initial host_in = HOST_INPUTS_RESET;
  task automatic set(input logic en, input logic cl, input logic md, input logic dr);
    @(negedge mclk);
    host_in.enable = en;
    host_in.sequencer_clear_low = cl;
    host_in.excitation_mode = md;
    host_in.direction_select = dr;
    // settle past the synchroniser before any step
    repeat (8) @(negedge mclk);
  endtask
  task automatic step(input int hi);
    @(negedge mclk);
    host_in.step_clock = 1'h1;
    repeat (hi) @(negedge mclk);
    host_in.step_clock = 1'h0;
    // period kept above the scaled minimum
    repeat (16) @(negedge mclk);
  endtask
  // clear pulse of lo cycles; kept short on purpose to trip the width flag
  task automatic clear_pulse(input int lo);
    @(negedge mclk);
    host_in.sequencer_clear_low = 1'h0;
    repeat (lo) @(negedge mclk);
    host_in.sequencer_clear_low = 1'h1;
    repeat (8) @(negedge mclk);
  endtask
endmodule // host_model

// file: tb/tb_stepper_phase_sequencer.sv
/*
  Self-checking bench for the stepper phase sequencer.
  Assumes host_model drives the pins; the checker is bound.
*/
`timescale 1ns/10ps
module tb_stepper_phase_sequencer;
  import stepper_pkg::*;
  localparam logic [31:0] TBL = 32'h8A264519;
  // small widths keep the flag scenarios short
  localparam int MIN_CYC = 4;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  host_inputs_t host_in;
  phase_drive_t phase_drive;
  step_index_t excitation_index;
  excitation_mode_t active_mode;
  run_state_t run_state;
  logic short_step_pulse;
  logic short_clear_pulse;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  host_model u_host (.mclk(mclk), .host_in(host_in));
  stepper_phase_sequencer #(.MIN_PULSE_CYC(MIN_CYC), .MIN_CLEAR_CYC(MIN_CYC)) DUT (
    .mclk(mclk),
    .nrst(nrst),
    .host_in(host_in),
    .phase_drive(phase_drive),
    .excitation_index(excitation_index),
    .active_mode(active_mode),
    .run_state(run_state),
    .short_step_pulse(short_step_pulse),
    .short_clear_pulse(short_clear_pulse)
  );
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // checks
  task automatic chk_pos(input step_index_t e, input logic on);
    phase_drive_t d;
    d = on ? phase_drive_t'(TBL[31-4*e -: 4]) : PHASES_OFF;
    tests_run++;
    if (excitation_index !== e || phase_drive !== d) begin
      num_errors++;
      $display("Error position exp %h/%h got %h/%h", e, d, excitation_index, phase_drive);
    end
  endtask
  task automatic chk_bit(input string n, input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic go(input logic md, input logic dr, input int n, input step_index_t e,
                    input step_index_t d);
    u_host.set(1'h1, 1'h1, md, dr);
    repeat (n) begin
      u_host.step(8);
      chk_pos(e, 1'h1);
      e = e + d;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk) nrst = 1'h1;
    repeat (12) @(negedge mclk);
    chk_bit("run", ST_CLEARED, run_state);
    u_host.set(1'h1, 1'h1, 1'h0, 1'h0);
    chk_pos(3'h0, 1'h1);
    go(1'h0, 1'h0, 4, 3'h1, 3'h2);
    go(1'h0, 1'h1, 4, 3'h5, 3'h6);
    go(1'h1, 1'h0, 3, 3'h0, 3'h1);
    go(1'h1, 1'h1, 1, 3'h1, 3'h7);
    chk_bit("mode", EXC_HALF_STEP, active_mode);
    u_host.set(1'h0, 1'h1, 1'h1, 1'h1);
    chk_bit("run", ST_HELD, run_state);
    u_host.step(8);
    chk_pos(3'h1, 1'h0);
    u_host.set(1'h1, 1'h1, 1'h1, 1'h1);
    chk_pos(3'h1, 1'h1);
    u_host.set(1'h1, 1'h0, 1'h0, 1'h0);
    u_host.step(8);
    chk_pos(3'h0, 1'h0);
    u_host.set(1'h1, 1'h1, 1'h0, 1'h0);
    // short high still steps but is flagged
    u_host.step(3);
    chk_pos(3'h1, 1'h1);
    chk_bit("short", 2'h1, {1'h0, short_step_pulse});
    // three-cycle clear: width flag set, step flag dropped, restart at gate one
    u_host.clear_pulse(3);
    chk_bit("flags", 2'h2, {short_clear_pulse, short_step_pulse});
    chk_pos(3'h0, 1'h1);
    wrap_up();
  end
endmodule // tb_stepper_phase_sequencer
